// ===== inc/dsr_pkg.sv
// constants and types shared by both ends of the 8:1 ddr serial link
// assumes one system clock per end; link timing is counted in its cycles
package dsr_pkg;

   // lane geometry
   localparam int DSR_LANES             = 4;
   localparam int DSR_LANE_BITS         = 8;
   localparam int DSR_WORD_BITS         = DSR_LANES * DSR_LANE_BITS;

   // one word period is eight half-periods of the fast bit clock
   localparam int DSR_HALF_PER_WORD     = 8;
   localparam int DSR_FAST_PER_WORD     = 4;
   localparam int DSR_FRAME_HIGH_HALVES = 4;

   typedef logic [2:0] dsr_phase_t;
   typedef logic [1:0] dsr_pair_idx_t;

   // half-period index at which the next word is captured
   localparam dsr_phase_t DSR_PH_LOAD      = 3'h6;
   localparam dsr_phase_t DSR_PH_RESET     = 3'h7;
   localparam dsr_phase_t DSR_PH_STEP      = 3'h1;
   localparam dsr_phase_t DSR_PH_HIGH_END  = 3'h4;
   localparam dsr_phase_t DSR_BIT_LAST     = 3'h7;
   localparam dsr_phase_t DSR_BIT_AFTER0   = 3'h1;
   localparam dsr_phase_t DSR_BIT_FIRST    = 3'h0;

   // system clock cycles per half-period of the fast bit clock
   localparam int DSR_HALF_DIV          = 4;
   // receiver: cycles strictly between the one that sees a clock edge and the data sample point;
   // at most DSR_HALF_DIV - 2, or the sample lands on the next bit
   localparam int DSR_SAMPLE_DLY        = 1;

   typedef enum logic {
      DSR_HUNT,
      DSR_RUN
   } dsr_rx_state_t;

endpackage : dsr_pkg

// ===== inc/dsr_link_if.sv
// link wires between the serializer and the deserializer ends
// each differential pair is carried as its true side only
`timescale 1ns/100ps
interface dsr_link_if #(
   parameter int NUM_LANES = dsr_pkg::DSR_LANES
);
   logic [NUM_LANES-1:0] lane;
   logic                 fwd_clk;
   logic                 frame;

   modport tx (
      output lane,
      output fwd_clk,
      output frame
   );

   modport rx (
      input  lane,
      input  fwd_clk,
      input  frame
   );
endinterface : dsr_link_if

// ===== rtl/dsr_quad_lane_serializer.sv
// transmit end: four lanes of 8:1 ddr serialization plus forwarded clock and frame
// assumes i_clk ticks once per half-period slot times HALF_DIV; user data is on i_clk
//
// Behaviour
// RULE1 - each lane sends one byte per word period
// RULE2 - capture on word clock, retime pairs, then ddr
// RULE3 - forwarded clock from ddr register with constants
// RULE4 - frame high four of eight half-periods
// RULE5 - frame output may be disabled or unused
// RULE6 - 32-bit word onto four lanes, clock, frame
// RULE7 - word and fast clocks strictly synchronous, ratio four
// RULE8 - msb-first needs word reversal at top level; the deserializer reverses the whole word itself when MSB_FIRST is set
// RULE9 - tiled blocks stay standalone; one clock per link
// RULE10 - fast clock distributed on rising edges only
// RULE11 - word clock is fast clock divided by four
// RULE12 - byte per lane, lowest bit sent first
// RULE13 - frame high half marks first four bits
`timescale 1ns/100ps
module dsr_quad_lane_serializer
   import dsr_pkg::*;
#(
   parameter int NUM_LANES = dsr_pkg::DSR_LANES,
   parameter int HALF_DIV  = dsr_pkg::DSR_HALF_DIV
)(
   input  wire logic                                       i_clk,
   input  wire logic                                       i_rst_n,
   input  wire logic [NUM_LANES*dsr_pkg::DSR_LANE_BITS-1:0] i_word,
   input  wire logic                                       i_frame_en,
   output logic                                            o_word_take,
   output logic                                            o_word_clk,
   dsr_link_if.tx                                          link
);
   import dsr_pkg::*;

   localparam int DIV_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = '0;
   localparam int WORD_W = NUM_LANES * DSR_LANE_BITS;

   ////////////////////////////////////////////////////////////////////////////
   // half-period timebase

   logic [DIV_W-1:0]     half_cnt_reg;
   logic [DIV_W-1:0]     half_cnt_next;
   dsr_phase_t           phase_reg;
   dsr_phase_t           phase_next;
   dsr_phase_t           phase_ahead;
   dsr_pair_idx_t        pair_idx;
   wire logic            half_tick;
   wire logic            load_word;
   wire logic            load_pair;
   wire logic            rise_half;
   wire logic            frame_half;
   wire logic            word_clk_half;

   // every register here runs on one clock; the fast clock is a slot count,
   // so all launches happen on rising i_clk edges only
   assign half_tick     = (half_cnt_reg == DIV_LAST); // RULE10
   assign half_cnt_next = half_tick ? DIV_ZERO : DIV_W'(half_cnt_reg + 1'b1);
   assign phase_next    = dsr_phase_t'(phase_reg + DSR_PH_STEP);
   assign phase_ahead   = dsr_phase_t'(phase_next + DSR_PH_STEP);
   // fast period index k covers half-periods 2k and 2k+1
   assign pair_idx      = phase_ahead[2:1];

   // word clock is one in four fast periods, taken from the same counter
   assign word_clk_half = (phase_next < DSR_PH_HIGH_END); // RULE7 RULE11
   assign load_word     = half_tick && (phase_next == DSR_PH_LOAD); // RULE2
   // pair loaded a half-period early so the ddr stage sees it settled
   assign load_pair     = half_tick && phase_next[0]; // RULE2
   assign rise_half     = ~phase_next[0];
   // frame high during the first four half-periods of each word
   assign frame_half    = i_frame_en && (phase_next < DSR_PH_HIGH_END); // RULE4 RULE5 RULE13

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         half_cnt_reg <= DIV_ZERO;
      end
      else
      begin
         half_cnt_reg <= half_cnt_next;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase_reg <= DSR_PH_RESET;
      end
      else if (half_tick)
      begin
         phase_reg <= phase_next;
      end
   end

   assign o_word_take = load_word;

   ////////////////////////////////////////////////////////////////////////////
   // word capture

   logic [WORD_W-1:0]    word_reg;

   // whole word taken at once; bits reorder only through the lane slicing
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         word_reg <= '0;
      end
      else if (load_word)
      begin
         word_reg <= i_word; // RULE2 RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-lane pair mux and ddr output stage

   wire logic [NUM_LANES-1:0] lane_bits;
   logic                 fwd_clk_reg;
   logic                 frame_reg;
   logic                 word_clk_reg;

   genvar g_lane;
   generate
      for (g_lane = 0; g_lane < NUM_LANES; g_lane++)
      begin : g_lanes
         logic [1:0]      pair_reg;
         logic            bit_reg;
         wire logic [1:0] pair_sel;

         // lane l owns byte l; bit 2k rides the high half, 2k+1 the low half
         assign pair_sel = word_reg[g_lane*DSR_LANE_BITS + 2*int'(pair_idx) +: 2]; // RULE12

         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               pair_reg <= '0;
            end
            else if (load_pair)
            begin
               pair_reg <= pair_sel; // RULE2
            end
         end

         // one bit per half-period, eight per word period
         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               bit_reg <= 1'b0;
            end
            else if (half_tick)
            begin
               bit_reg <= rise_half ? pair_reg[0] : pair_reg[1]; // RULE1
            end
         end

         // one register per lane keeps each lane bit on a single driver
         assign lane_bits[g_lane] = bit_reg;
      end
   endgenerate

   // clock and frame share the data path timing, so skew stays minimal;
   // constant one on the high half, constant zero on the low half
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         fwd_clk_reg <= 1'b0;
      end
      else if (half_tick)
      begin
         fwd_clk_reg <= rise_half; // RULE3
      end
   end

   // frame has its own register, timed exactly like the lanes
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         frame_reg <= 1'b0;
      end
      else if (half_tick)
      begin
         frame_reg <= frame_half; // RULE4
      end
   end

   // user-side word clock, on the same slots as the forwarded clock
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         word_clk_reg <= 1'b0;
      end
      else if (half_tick)
      begin
         word_clk_reg <= word_clk_half; // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link drive

   // each block drives its own clock and frame; when tiling, pick one of each
   assign link.lane    = lane_bits; // RULE6 RULE9
   assign link.fwd_clk = fwd_clk_reg; // RULE9
   assign link.frame   = frame_reg; // RULE5
   assign o_word_clk   = word_clk_reg;

endmodule : dsr_quad_lane_serializer

// ===== rtl/dsr_quad_lane_deserializer.sv
// receive end: samples the forwarded clock, frame and lanes on its own clock
// assumes link half-period spans several i_clk cycles; lsb of each byte first
`timescale 1ns/100ps
module dsr_quad_lane_deserializer
   import dsr_pkg::*;
#(
   parameter int   NUM_LANES  = dsr_pkg::DSR_LANES,
   parameter int   SAMPLE_DLY = dsr_pkg::DSR_SAMPLE_DLY,
   parameter logic MSB_FIRST  = 1'b0,
   parameter logic USE_FRAME  = 1'b1
)(
   input  wire logic                                       i_clk,
   input  wire logic                                       i_rst_n,
   dsr_link_if.rx                                          link,
   output logic [NUM_LANES*dsr_pkg::DSR_LANE_BITS-1:0]     o_word,
   output logic                                            o_word_valid,
   output logic                                            o_locked
);
   import dsr_pkg::*;

   localparam int VEC_W  = NUM_LANES + 2;
   localparam int WORD_W = NUM_LANES * DSR_LANE_BITS;
   localparam int DLY_W  = $clog2(SAMPLE_DLY + 2);
   localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(SAMPLE_DLY);
   localparam logic [DLY_W-1:0] DLY_ZERO = '0;
   localparam int CLK_POS = 0;
   localparam int FRM_POS = NUM_LANES + 1;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [VEC_W-1:0]  s1_reg;
   logic [VEC_W-1:0]  s2_reg;
   logic              clk_d_reg;
   wire logic [VEC_W-1:0] pins;

   assign pins = {link.frame, link.lane, link.fwd_clk};

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         clk_d_reg <= 1'b0;
      end
      else
      begin
         s1_reg    <= pins;
         s2_reg    <= s1_reg;
         clk_d_reg <= s2_reg[CLK_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge find and delayed sample point

   logic [DLY_W-1:0]  dly_reg;
   logic              armed_reg;
   wire logic         clk_edge;
   wire logic         sample;

   // both clock edges carry a bit; the delay moves the sample off the edge
   assign clk_edge = s2_reg[CLK_POS] ^ clk_d_reg;
   assign sample   = armed_reg && (dly_reg == DLY_ZERO);

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         dly_reg   <= DLY_ZERO;
         armed_reg <= 1'b0;
      end
      else if (clk_edge)
      begin
         dly_reg   <= DLY_LOAD;
         armed_reg <= 1'b1;
      end
      else if (sample)
      begin
         armed_reg <= 1'b0;
      end
      else if (armed_reg)
      begin
         dly_reg <= DLY_W'(dly_reg - 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // framing and assembly

   dsr_rx_state_t     state_reg;
   dsr_rx_state_t     state_next;
   dsr_phase_t        bit_reg;
   dsr_phase_t        bit_next;
   logic              frame_d_reg;
   logic [WORD_W-1:0] shift_reg;
   logic [WORD_W-1:0] word_reg;
   logic              valid_reg;
   wire logic         frame_bit;
   wire logic         frame_start;
   wire logic         word_done;
   wire logic [WORD_W-1:0] assembled;
   wire logic [WORD_W-1:0] reversed;

   assign frame_bit   = s2_reg[FRM_POS];
   // frame rise marks bit 0 of every lane
   assign frame_start = USE_FRAME && frame_bit && !frame_d_reg; // RULE5 RULE13

   always_comb
   begin
      state_next = state_reg;
      bit_next   = bit_reg;
      case (state_reg)
         DSR_HUNT:
         begin
            if (!USE_FRAME || frame_start)
            begin
               state_next = DSR_RUN;
               // this sample is already bit 0, framed or not
               bit_next   = DSR_BIT_AFTER0;
            end
         end
         DSR_RUN:
         begin
            bit_next = frame_start ? DSR_BIT_AFTER0 : dsr_phase_t'(bit_reg + DSR_PH_STEP);
         end
         default:
         begin
            state_next = DSR_HUNT;
         end
      endcase
   end

   assign word_done = (state_reg == DSR_RUN) && (bit_reg == DSR_BIT_LAST) && !frame_start;

   genvar g_lane;
   genvar g_bit;
   generate
      for (g_lane = 0; g_lane < NUM_LANES; g_lane++)
      begin : g_lanes
         // new bit enters at the top so the first bit ends at bit 0
         assign assembled[g_lane*DSR_LANE_BITS +: DSR_LANE_BITS] =
            {s2_reg[g_lane+1], shift_reg[g_lane*DSR_LANE_BITS+1 +: DSR_LANE_BITS-1]}; // RULE12
      end
      for (g_bit = 0; g_bit < WORD_W; g_bit++)
      begin : g_rev
         assign reversed[g_bit] = assembled[WORD_W-1-g_bit]; // RULE8
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_reg   <= DSR_HUNT;
         bit_reg     <= DSR_BIT_FIRST;
         frame_d_reg <= 1'b0;
         shift_reg   <= '0;
         word_reg    <= '0;
         valid_reg   <= 1'b0;
      end
      else
      begin
         valid_reg <= sample && word_done;
         if (sample)
         begin
            state_reg   <= state_next;
            bit_reg     <= bit_next;
            frame_d_reg <= frame_bit;
            shift_reg   <= assembled;
            if (word_done)
            begin
               word_reg <= MSB_FIRST ? reversed : assembled; // RULE8
            end
         end
      end
   end

   assign o_word       = word_reg;
   assign o_word_valid = valid_reg;
   assign o_locked     = (state_reg == DSR_RUN);

endmodule : dsr_quad_lane_deserializer

// ===== test/dsr_link_checker.sv
// checker for the link wires and tx user pins of the 8:1 serial link
// assumes tx HALF_DIV of 4, four lanes, one clock domain; instanced beside the link
`timescale 1ns/100ps
module dsr_link_checker (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  lane,
   input  wire logic        fwd_clk,
   input  wire logic        frame,
   input  wire logic [31:0] i_word,
   input  wire logic        i_frame_en,
   input  wire logic        o_word_take
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   logic [5:0] high_reg;

   // bit k of every lane, lane 0 lowest
   function automatic logic [3:0] lane_bits(input logic [31:0] w, input int k);
      return {w[24+k], w[16+k], w[8+k], w[k]};
   endfunction : lane_bits

   // frame high run length, checked when the run ends
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         high_reg <= 6'h00;
      else
         high_reg <= frame ? high_reg + 6'h01 : 6'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   clk_period_a : assert property (
      $changed(fwd_clk) |=> $stable(fwd_clk)[*3] ##1 $changed(fwd_clk))
      else $error("forwarded clock half period is not four cycles");
   lane_edge_a : assert property ($changed(lane) |-> $changed(fwd_clk))
      else $error("lane moved off a clock edge");
   frame_edge_a : assert property ($changed(frame) |-> $changed(fwd_clk))
      else $error("frame moved off a clock edge");
   frame_en_a : assert property ($rose(frame) |-> $past(i_frame_en))
      else $error("frame rose while disabled");
   frame_high_a : assert property ($fell(frame) |-> high_reg == 6'h10)
      else $error("frame high run is not four half periods");
   frame_align_a : assert property ($rose(frame) |-> $rose(fwd_clk))
      else $error("frame rise not on a rising clock edge");
   take_rate_a : assert property (o_word_take |-> ##32 o_word_take)
      else $error("word take not every word period");
   word_start_a : assert property (
      o_word_take |-> ##9 ($rose(fwd_clk) && frame == $past(i_frame_en)))
      else $error("word does not start at frame start");
   first_bit_a : assert property (
      o_word_take |-> ##9 lane == lane_bits($past(i_word, 9), 0))
      else $error("first bit is not the lowest of each byte");
   last_bit_a : assert property (
      o_word_take |-> ##37 lane == lane_bits($past(i_word, 37), 7))
      else $error("last bit is not the highest of each byte");
endmodule : dsr_link_checker

// ===== test/tb_top.sv
// self-checking bench: tx end facing three rx ends (lsb first, msb first, unframed) on one link
// assumes one 100 MHz clock for all ends; inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module tb_top;
   logic        i_clk;
   logic        i_rst_n;
   logic [31:0] i_word;
   logic        i_frame_en;
   logic        o_word_take;
   logic        o_word_clk;
   logic [31:0] rx_word;
   logic [31:0] rv_word;
   logic        rx_valid;
   logic        rv_valid;
   logic        rx_locked;
   logic [31:0] nf_word;
   logic        nf_valid;
   logic [31:0] rx_q[$];
   logic [31:0] rv_q[$];
   logic [31:0] nf_q[$];
   int          n_errors;
   int          cmp_count;

   dsr_link_if link_if ();
   dsr_quad_lane_serializer i_dsr_quad_lane_serializer (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_word(i_word), .i_frame_en(i_frame_en), .o_word_take(o_word_take),
      .o_word_clk(o_word_clk), .link(link_if.tx));
   dsr_quad_lane_deserializer i_dsr_quad_lane_deserializer (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .link(link_if.rx), .o_word(rx_word), .o_word_valid(rx_valid), .o_locked(rx_locked));
   dsr_quad_lane_deserializer #(.MSB_FIRST(1'b1)) i_dsr_quad_lane_deserializer_rev (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_if.rx), .o_word(rv_word),
      .o_word_valid(rv_valid), .o_locked());
   dsr_quad_lane_deserializer #(.USE_FRAME(1'b0)) i_dsr_quad_lane_deserializer_nf (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_if.rx), .o_word(nf_word),
      .o_word_valid(nf_valid), .o_locked());
   dsr_link_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .lane(link_if.lane),
      .fwd_clk(link_if.fwd_clk), .frame(link_if.frame), .i_word(i_word),
      .i_frame_en(i_frame_en), .o_word_take(o_word_take));

   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   always @(posedge i_clk)
   begin
      if (rx_valid === 1'b1) rx_q.push_back(rx_word);
      if (rv_valid === 1'b1) rv_q.push_back(rv_word);
      if (nf_valid === 1'b1) nf_q.push_back(nf_word);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         $display("wrong value at %0t: %s", $time, msg);
         n_errors++;
      end
   endtask : check

   task stop_test();
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // holds the word until the take edge has passed
   task automatic send_word(input logic [31:0] w);
      int n;
      i_word = w;
      n = 0;
      while (o_word_take !== 1'b1 && n < 40)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check(n < 40, "word never taken");
      if (n >= 40) stop_test();
      @(posedge i_clk);
      #1;
   endtask : send_word

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stream_words();
      logic [31:0] w[6];
      logic [31:0] r;
      int          j;
      w = '{32'h0f1e2d3c, 32'hffffffff, 32'h00000000, 32'h80000001, 32'ha5c396e1, 32'h01234567};
      j = -1;
      rx_q.delete();
      rv_q.delete();
      nf_q.delete();
      foreach (w[k]) send_word(w[k]);
      repeat (100) @(posedge i_clk);
      #1;
      foreach (rx_q[k]) if (j < 0 && rx_q[k] === w[0]) j = k;
      check(j >= 0 && rx_q.size() >= j + 6 && rv_q.size() >= j + 6, "words lost");
      check(rx_locked === 1'b1, "receiver not locked");
      check(nf_q.size() >= j + 6, "unframed words lost");
      if (j >= 0)
      begin
         for (int k = 0; k < 6; k++)
         begin
            r = {<<{w[k]}};
            check(rx_q[j+k] === w[k], "lane data");
            check(rv_q[j+k] === r, "reversed data");
            check(nf_q[j+k] === w[k], "unframed data");
         end
      end
   endtask : stream_words

   // high counts over 64 cycles, a whole number of word periods
   task automatic duty(input logic en);
      int clk_hi;
      int frm_hi;
      int wclk_hi;
      clk_hi = 0;
      frm_hi = 0;
      wclk_hi = 0;
      send_word(32'h5a5ac3c3);
      i_frame_en = en;
      repeat (40) @(posedge i_clk);
      repeat (64)
      begin
         @(posedge i_clk);
         #1;
         clk_hi += int'(link_if.fwd_clk === 1'b1);
         frm_hi += int'(link_if.frame === 1'b1);
         wclk_hi += int'(o_word_clk === 1'b1);
      end
      check(clk_hi == 32, "clock duty");
      check(frm_hi == (en ? 32 : 0), "frame duty");
      check(wclk_hi == 32, "word clock duty");
   endtask : duty

   task automatic mid_reset();
      repeat (13) @(posedge i_clk);
      #1;
      i_rst_n = 1'b0;
      #1;
      check(link_if.fwd_clk === 1'b0 && link_if.frame === 1'b0, "link not cleared");
      check(link_if.lane === 4'h0 && o_word_take === 1'b0, "lanes not cleared");
      repeat (3) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      stream_words();
   endtask : mid_reset

   initial
   begin
      i_rst_n = 1'b0;
      i_word = 32'h00000000;
      i_frame_en = 1'b1;
      n_errors = 0;
      cmp_count = 0;
      repeat (10) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      stream_words();
      duty(1'b0);
      duty(1'b1);
      mid_reset();
      stop_test();
   end
endmodule : tb_top
